/* hdl/tpwm_cfg.svh */
// Constants for the two-channel timer and pulse-width block
`ifndef TPWM_CFG_SVH
`define TPWM_CFG_SVH

// Clock selector codes
`define TPWM_CLKS_STOP 2'h0
`define TPWM_CLKS_BUS 2'h1
`define TPWM_CLKS_UNUSED 2'h2
`define TPWM_CLKS_XTAL 2'h3

// Channel mode codes (mode high:low)
`define TPWM_MODE_CAPTURE 2'h0
`define TPWM_MODE_COMPARE 2'h1

// Edge/level codes: capture edges, compare actions, PWM polarity
`define TPWM_EL_OFF 2'h0
`define TPWM_EL_RISE 2'h1
`define TPWM_EL_FALL 2'h2
`define TPWM_EL_BOTH 2'h3
`define TPWM_OC_TOGGLE 2'h1
`define TPWM_OC_CLEAR 2'h2
`define TPWM_OC_SET 2'h3

// Counter limits and reset values
`define TPWM_CNT_ZERO 16'h0000
`define TPWM_CNT_FULL 16'hFFFF
`define TPWM_RST_CLKS 2'h0
`define TPWM_RST_PS 3'h0

// Rates: system clock and crystal-derived counter clock
`define TPWM_SYS_CLK_HZ 50000000
`define TPWM_XTAL_CLK_HZ 500000

`endif

/* hdl/tpwm_pkg.sv */
// Types shared by the timer and pulse-width block
package tpwm_pkg;
   // Counting direction of the shared counter
   typedef enum logic {
      TPWM_DIR_UP,
      TPWM_DIR_DOWN
   } tpwm_dir_t;

   typedef logic [15:0] tpwm_count_t;
endpackage

/* hdl/tpwm_chan_if.sv */
// Time base carried from the counter core to each channel
`timescale 1ns/1ns
interface tpwm_chan_if;
   import tpwm_pkg::*;
   tpwm_count_t count;
   logic tick;
   logic center_aligned_pwm;

   modport core (output count, output tick, output center_aligned_pwm);
   modport chan (input count, input tick, input center_aligned_pwm);
endinterface // tpwm_chan_if

/* hdl/tpwm_channel.sv */
// One timer channel: input capture, output compare or PWM
`timescale 1ns/1ns
`include "tpwm_cfg.svh"
module tpwm_channel
   import tpwm_pkg::*;
(
   input wire logic clock_i,
   input wire logic nrst_i,
   tpwm_chan_if.chan tb,
   input wire logic [1:0] mode_i,
   input wire logic [1:0] edge_level_i,
   input wire tpwm_count_t duty_i,
   input wire tpwm_count_t compare_i,
   input wire logic pin_i,
   output logic event_o,
   output logic pin_o,
   output logic pin_oe_o
);
   logic prev_q;
   logic rise;
   logic fall;
   logic is_cap;
   logic is_oc;
   logic is_pwm;
   logic match;
   logic active;

   // Mode decode; center-aligned overrides every channel
   assign is_cap = !tb.center_aligned_pwm && mode_i == `TPWM_MODE_CAPTURE;
   assign is_oc = !tb.center_aligned_pwm && mode_i == `TPWM_MODE_COMPARE;
   assign is_pwm = tb.center_aligned_pwm || mode_i[1];
   assign rise = pin_i && !prev_q;
   assign fall = !pin_i && prev_q;
   assign match = tb.tick && tb.count == compare_i;
   assign active = tb.count < duty_i;

   // Input is synchronous, so one flop is enough for edges
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= pin_i;
      end
   end

   // Capture on the chosen edges, compare or PWM on a match
   always_comb begin
      if (is_cap) begin
         event_o = (edge_level_i[0] && rise) ||
                   (edge_level_i[1] && fall);
      end else begin
         event_o = match;
      end
   end

   // Pin drive; a channel with no pin leaves it to general I/O
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pin_o <= 1'b0;
         pin_oe_o <= 1'b0;
      end else begin
         pin_oe_o <= !is_cap && edge_level_i != `TPWM_EL_OFF;
         if (is_pwm) begin
            // Low-true when the low bit is set
            pin_o <= active ^ edge_level_i[0];
         end else if (is_oc && match) begin
            unique case (edge_level_i)
               `TPWM_OC_TOGGLE: pin_o <= !pin_o;
               `TPWM_OC_CLEAR: pin_o <= 1'b0;
               `TPWM_OC_SET: pin_o <= 1'b1;
               default: pin_o <= pin_o;
            endcase
         end
      end
   end
endmodule // tpwm_channel

/* hdl/tpwm_top.sv */
// Two-channel 16-bit timer with capture, compare and PWM
// Notes on behaviour
// - Selector: 00 stops, 01 bus clock, 10 unused, 11 crystal clock.
// - Selected clock passes a divide-by 1 to 128 prescaler.
// - One 16-bit counter, up normally, up/down in center-aligned mode.
// - Modulo sets range; 0x0000 or 0xFFFF means full free run.
// - Counter reads return current count without disturbing it.
// - Writing either counter byte resets the counter, data ignored.
// - Each channel is capture, compare or buffered edge PWM.
// - The one shared counter, up or up/down, is the time base of every channel.
// - Capture on rising, falling or either input edge.
// - Compare match sets, clears or toggles the pin.
// - PWM polarity selectable; center mode applies to all, buffered.
// - One interrupt per channel plus one for terminal count.
// - Route bit feeds channel 0 from pin or slow oscillator.
// - Crystal selection counts a 500 kHz crystal-derived clock.
// - Channel pins needing no function stay with general I/O.
// - Overflow sets on wrap to zero, or step down in center mode.
// - Clear overflow: read while set, then write zero; re-arm on new.
// - Overflow interrupt asserts while enabled and flag is one.
// - Prescale code gives divisor two to the power of the code.
`timescale 1ns/1ns
`include "tpwm_cfg.svh"
module tpwm_top
   import tpwm_pkg::*;
#(
   parameter int NUM_CH = 2,
   parameter int PS_BITS = 7
)
(
   input wire logic clock_i,
   input wire logic nrst_i,
   // Control bits
   input wire logic clock_select_high_i,
   input wire logic clock_select_low_i,
   input wire logic [2:0] prescale_code_i,
   input wire logic center_aligned_pwm_i,
   input wire logic overflow_irq_enable_i,
   input wire logic [7:0] modulo_value_high_i,
   input wire logic [7:0] modulo_value_low_i,
   input wire logic slow_osc_route_select_i,
   // Clock and oscillator inputs
   input wire logic crystal_derived_clock_i,
   input wire logic slow_oscillator_i,
   // Counter access
   input wire logic counter_wr_high_i,
   input wire logic counter_wr_low_i,
   output tpwm_count_t counter_value_o,
   // Overflow status access
   input wire logic status_rd_i,
   input wire logic overflow_wr_i,
   input wire logic overflow_wr_data_i,
   output logic overflow_flag_o,
   output logic overflow_irq_o,
   // Channel control
   input wire logic [NUM_CH-1:0][1:0] ch_mode_i,
   input wire logic [NUM_CH-1:0][1:0] ch_edge_level_i,
   input wire logic [NUM_CH-1:0] ch_irq_enable_i,
   input wire logic [NUM_CH-1:0] ch_value_wr_i,
   input wire logic [NUM_CH-1:0][15:0] ch_value_data_i,
   input wire logic [NUM_CH-1:0] ch_status_rd_i,
   input wire logic [NUM_CH-1:0] ch_flag_wr_i,
   input wire logic [NUM_CH-1:0] ch_flag_wr_data_i,
   output logic [NUM_CH-1:0][15:0] ch_value_o,
   output logic [NUM_CH-1:0] ch_flag_o,
   output logic [NUM_CH-1:0] ch_irq_o,
   // Shared port pins
   input wire logic [NUM_CH-1:0] port_a_upper_pins_i,
   output logic [NUM_CH-1:0] port_a_upper_pins_o,
   output logic [NUM_CH-1:0] port_a_upper_pins_oe_o
);
   // Divide mask for a prescale code: 2**code - 1
   function automatic logic [PS_BITS-1:0] ps_mask(input logic [2:0] code);
      logic [PS_BITS:0] one;
      one = {{PS_BITS{1'b0}}, 1'b1};
      ps_mask = PS_BITS'((one << code) - one);
   endfunction

   // Counter limit; both extremes of the modulo mean full range
   function automatic tpwm_count_t top_of(input tpwm_count_t m);
      if (m == `TPWM_CNT_ZERO || m == `TPWM_CNT_FULL) begin
         top_of = `TPWM_CNT_FULL;
      end else begin
         top_of = m;
      end
   endfunction

   tpwm_chan_if tbus ();

   logic [1:0] clk_sel;
   logic xtal_prev_q;
   logic src_en;
   logic [PS_BITS-1:0] ps_q;
   logic tick;
   logic cnt_wr;
   tpwm_count_t cnt_q;
   tpwm_count_t top;
   tpwm_dir_t dir_q;
   logic ovf_evt;
   logic ovf_q;
   logic ovf_armed_q;
   logic [NUM_CH-1:0] ch_evt;
   logic [NUM_CH-1:0] ch_in;
   logic [NUM_CH-1:0] ch_armed_q;
   logic [NUM_CH-1:0][15:0] duty_q;

   assign clk_sel = {clock_select_high_i, clock_select_low_i};
   assign top = top_of({modulo_value_high_i, modulo_value_low_i});
   assign cnt_wr = counter_wr_high_i || counter_wr_low_i;

   // Crystal clock arrives as a synchronous level; its rising edge
   // is the count enable, so the block keeps a single clock domain
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         xtal_prev_q <= 1'b0;
      end else begin
         xtal_prev_q <= crystal_derived_clock_i;
      end
   end

   // Source select; the unused code gives no count enable, like stop
   always_comb begin
      unique case (clk_sel)
         `TPWM_CLKS_BUS: src_en = 1'b1;
         `TPWM_CLKS_XTAL: src_en = crystal_derived_clock_i &&
                                   !xtal_prev_q;
         `TPWM_CLKS_STOP: src_en = 1'b0;
         `TPWM_CLKS_UNUSED: src_en = 1'b0;
      endcase
   end

   // Prescaler sits after source selection; cleared on counter write
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ps_q <= '0;
      end else if (cnt_wr) begin
         ps_q <= '0;
      end else if (src_en) begin
         ps_q <= ps_q + PS_BITS'(1);
      end
   end

   // One tick each time the low code bits of the prescaler fill up
   assign tick = src_en &&
                 (ps_q & ps_mask(prescale_code_i)) ==
                 ps_mask(prescale_code_i);

   // Overflow moment: leaving the top, by wrap or by turning down
   assign ovf_evt = tick && cnt_q == top;

   // Shared counter; reads only look at cnt_q so never disturb it
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_q <= `TPWM_CNT_ZERO;
         dir_q <= TPWM_DIR_UP;
      end else if (cnt_wr) begin
         cnt_q <= `TPWM_CNT_ZERO;
         dir_q <= TPWM_DIR_UP;
      end else if (tick) begin
         if (!center_aligned_pwm_i) begin
            dir_q <= TPWM_DIR_UP;
            if (cnt_q >= top) begin
               cnt_q <= `TPWM_CNT_ZERO;
            end else begin
               cnt_q <= cnt_q + 16'h0001;
            end
         end else if (dir_q == TPWM_DIR_UP) begin
            if (cnt_q >= top) begin
               dir_q <= TPWM_DIR_DOWN;
               cnt_q <= cnt_q - 16'h0001;
            end else begin
               cnt_q <= cnt_q + 16'h0001;
            end
         end else begin
            if (cnt_q == `TPWM_CNT_ZERO) begin
               dir_q <= TPWM_DIR_UP;
               cnt_q <= cnt_q + 16'h0001;
            end else begin
               cnt_q <= cnt_q - 16'h0001;
            end
         end
      end
   end

   assign counter_value_o = cnt_q;

   // Time base for all channels
   assign tbus.count = cnt_q;
   assign tbus.tick = tick;
   assign tbus.center_aligned_pwm = center_aligned_pwm_i;

   // Overflow flag; a new overflow beats a clear in the same cycle
   // and also drops the arming, so the clear must start over
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ovf_q <= 1'b0;
         ovf_armed_q <= 1'b0;
      end else if (ovf_evt) begin
         ovf_q <= 1'b1;
         ovf_armed_q <= 1'b0;
      end else if (overflow_wr_i && !overflow_wr_data_i && ovf_armed_q) begin
         ovf_q <= 1'b0;
         ovf_armed_q <= 1'b0;
      end else if (status_rd_i && ovf_q) begin
         ovf_armed_q <= 1'b1;
      end
   end

   assign overflow_flag_o = ovf_q;
   assign overflow_irq_o = ovf_q && overflow_irq_enable_i;

   // Channel 0 may watch the slow oscillator instead of its pin
   always_comb begin
      ch_in = port_a_upper_pins_i;
      if (slow_osc_route_select_i) begin
         ch_in[0] = slow_oscillator_i;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         logic is_cap;
         logic is_pwm;

         assign is_cap = !center_aligned_pwm_i &&
                         ch_mode_i[g] == `TPWM_MODE_CAPTURE;
         assign is_pwm = center_aligned_pwm_i || ch_mode_i[g][1];

         // Value register: software writes it, a capture loads it
         always_ff @(posedge clock_i or negedge nrst_i) begin
            if (!nrst_i) begin
               ch_value_o[g] <= `TPWM_CNT_ZERO;
            end else if (is_cap && ch_evt[g]) begin
               ch_value_o[g] <= cnt_q;
            end else if (ch_value_wr_i[g]) begin
               ch_value_o[g] <= ch_value_data_i[g];
            end
         end

         // PWM duty only takes a new value at a period boundary, or at once with the
         // selector at stop, so a write mid-period while counting can never cut a pulse short
         always_ff @(posedge clock_i or negedge nrst_i) begin
            if (!nrst_i) begin
               duty_q[g] <= `TPWM_CNT_ZERO;
            end else if (!is_pwm || clk_sel == `TPWM_CLKS_STOP ||
                         ovf_evt) begin
               duty_q[g] <= ch_value_o[g];
            end
         end

         // Channel flag with the same read-then-write-zero clear
         always_ff @(posedge clock_i or negedge nrst_i) begin
            if (!nrst_i) begin
               ch_flag_o[g] <= 1'b0;
               ch_armed_q[g] <= 1'b0;
            end else if (ch_evt[g]) begin
               ch_flag_o[g] <= 1'b1;
               ch_armed_q[g] <= 1'b0;
            end else if (ch_flag_wr_i[g] && !ch_flag_wr_data_i[g] &&
                         ch_armed_q[g]) begin
               ch_flag_o[g] <= 1'b0;
               ch_armed_q[g] <= 1'b0;
            end else if (ch_status_rd_i[g] && ch_flag_o[g]) begin
               ch_armed_q[g] <= 1'b1;
            end
         end

         assign ch_irq_o[g] = ch_flag_o[g] && ch_irq_enable_i[g];

         tpwm_channel u_ch (
            .clock_i(clock_i),
            .nrst_i(nrst_i),
            .tb(tbus.chan),
            .mode_i(ch_mode_i[g]),
            .edge_level_i(ch_edge_level_i[g]),
            .duty_i(duty_q[g]),
            .compare_i(is_pwm ? duty_q[g] : ch_value_o[g]),
            .pin_i(ch_in[g]),
            .event_o(ch_evt[g]),
            .pin_o(port_a_upper_pins_o[g]),
            .pin_oe_o(port_a_upper_pins_oe_o[g])
         );
      end
   endgenerate

   // Reset leaves the selector at stop and every control cleared;
   // the controls themselves are ports held by the register owner
endmodule // tpwm_top

/* dv/tpwm_pins_model.sv */
// Far-side model: channel pins, slow oscillator, crystal clock
`timescale 1ns/1ns
module tpwm_pins_model #(
   parameter int XTAL_HALF_NS = 1000,
   parameter int SLOW_HALF_NS = 3000
) (
   input wire logic [1:0] drive_i,
   input wire logic [1:0] pin_o_i,
   input wire logic [1:0] pin_oe_i,
   output logic [1:0] pin_level_o,
   output logic xtal_o,
   output logic slow_o
);
   // Wire level: the block wins while it drives, else the far side
   assign pin_level_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & drive_i);
   // Crystal clock runs free; edges fall between sampling edges
   initial xtal_o = 1'b0;
   always #(XTAL_HALF_NS) xtal_o = ~xtal_o;
   // Slow oscillator shortened so the run stays brief
   initial slow_o = 1'b0;
   always #(SLOW_HALF_NS) slow_o = ~slow_o;
endmodule // tpwm_pins_model

/* dv/tpwm_properties.sv */
// Port-level assertions for the timer and pulse-width block
`timescale 1ns/1ns
`include "tpwm_cfg.svh"
module tpwm_properties
   import tpwm_pkg::*;
#(
   parameter int NUM_CH = 2
)
(
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic clock_select_high_i,
   input wire logic clock_select_low_i,
   input wire logic [2:0] prescale_code_i,
   input wire logic center_aligned_pwm_i,
   input wire logic overflow_irq_enable_i,
   input wire logic [7:0] modulo_value_high_i,
   input wire logic [7:0] modulo_value_low_i,
   input wire logic counter_wr_high_i,
   input wire logic counter_wr_low_i,
   input wire tpwm_count_t counter_value_o,
   input wire logic status_rd_i,
   input wire logic overflow_wr_i,
   input wire logic overflow_wr_data_i,
   input wire logic overflow_flag_o,
   input wire logic overflow_irq_o,
   input wire logic [NUM_CH-1:0][1:0] ch_mode_i,
   input wire logic [NUM_CH-1:0][1:0] ch_edge_level_i,
   input wire logic [NUM_CH-1:0] ch_value_wr_i,
   input wire logic [NUM_CH-1:0][15:0] ch_value_o,
   input wire logic [NUM_CH-1:0] ch_flag_o,
   input wire logic [NUM_CH-1:0] port_a_upper_pins_i,
   input wire logic [NUM_CH-1:0] port_a_upper_pins_o,
   input wire logic [NUM_CH-1:0] port_a_upper_pins_oe_o
);
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!nrst_i);
   tpwm_count_t top;
   logic run1;
   // Count steps on every edge: bus clock, divide by one, up, no write
   assign top = {modulo_value_high_i, modulo_value_low_i};
   assign run1 = !clock_select_high_i && clock_select_low_i &&
      prescale_code_i == 3'h0 && !center_aligned_pwm_i &&
      !counter_wr_high_i && !counter_wr_low_i;
   property p_stop;
      !clock_select_low_i && !counter_wr_high_i && !counter_wr_low_i
         |=> $stable(counter_value_o);
   endproperty
   a_stop: assert property (p_stop) else $error("stopped count moved");
   property p_wr;
      counter_wr_high_i || counter_wr_low_i |=> counter_value_o == 16'h0000;
   endproperty
   a_wr: assert property (p_wr) else $error("write kept count");
   property p_step;
      run1 && (top == 16'h0000 || top == 16'hFFFF)
         |=> counter_value_o == $past(counter_value_o) + 16'h0001;
   endproperty
   a_step: assert property (p_step) else $error("bad step");
   property p_ovf;
      run1 && top != 16'h0000 && counter_value_o == top
         |=> overflow_flag_o && counter_value_o == 16'h0000;
   endproperty
   a_ovf: assert property (p_ovf) else $error("bad wrap");
   property p_irq;
      overflow_irq_o == (overflow_flag_o && overflow_irq_enable_i);
   endproperty
   a_irq: assert property (p_irq) else $error("bad overflow irq");
   property p_one;
      overflow_flag_o && overflow_wr_i && overflow_wr_data_i |=> overflow_flag_o;
   endproperty
   a_one: assert property (p_one) else $error("write one cleared");
   // Clear sequence with the counter stopped, so no new overflow races it
   sequence s_armed;
      status_rd_i && overflow_flag_o && !clock_select_low_i ##1
      overflow_wr_i && !overflow_wr_data_i && !clock_select_low_i;
   endsequence
   property p_clr;
      s_armed |=> !overflow_flag_o;
   endproperty
   a_clr: assert property (p_clr) else $error("flag not cleared");
   property p_cap;
      ch_mode_i[1] == `TPWM_MODE_CAPTURE && ch_edge_level_i[1] == `TPWM_EL_RISE
      && !center_aligned_pwm_i && $rose(port_a_upper_pins_i[1])
         |=> ch_flag_o[1] && ch_value_o[1] == $past(counter_value_o);
   endproperty
   a_cap: assert property (p_cap) else $error("bad capture");
   property p_cmp;
      ch_mode_i[1] == `TPWM_MODE_COMPARE && ch_edge_level_i[1] == `TPWM_OC_SET
      && run1 && !ch_value_wr_i[1] && counter_value_o == ch_value_o[1]
         |=> port_a_upper_pins_o[1] && port_a_upper_pins_oe_o[1];
   endproperty
   a_cmp: assert property (p_cmp) else $error("compare set missed");
endmodule // tpwm_properties

/* dv/tb_top.sv */
// Self-checking bench for the timer and pulse-width block
`timescale 1ns/1ns
module tb_top;
   import tpwm_pkg::*;
   logic clk = 1'b0, nrst = 1'b0, sh = 1'b0, sl = 1'b0, cpw = 1'b0;
   logic oie = 1'b0, rte = 1'b0, cwh = 1'b0, cwl = 1'b0, srd = 1'b0;
   logic owr = 1'b0, owd = 1'b0, xtal, slow, flag, irq;
   logic [2:0] ps = 3'h0;
   logic [15:0] modv = 16'h0000;
   tpwm_count_t cnt;
   logic [1:0][1:0] mode = '0, el = '0;
   logic [1:0] cie = '0, cvw = '0, csr = '0, cfw = '0, drv = '0;
   logic [1:0] cflag, cirq, pin, pout, poe;
   logic [1:0][15:0] cvd = '0, cval;
   int error_cnt = 0;
   int checks_done = 0;
   tpwm_top dut (.clock_i(clk), .nrst_i(nrst), .clock_select_high_i(sh),
      .clock_select_low_i(sl), .prescale_code_i(ps),
      .center_aligned_pwm_i(cpw), .overflow_irq_enable_i(oie),
      .modulo_value_high_i(modv[15:8]), .modulo_value_low_i(modv[7:0]),
      .slow_osc_route_select_i(rte), .crystal_derived_clock_i(xtal),
      .slow_oscillator_i(slow), .counter_wr_high_i(cwh),
      .counter_wr_low_i(cwl), .counter_value_o(cnt), .status_rd_i(srd),
      .overflow_wr_i(owr), .overflow_wr_data_i(owd), .overflow_flag_o(flag),
      .overflow_irq_o(irq), .ch_mode_i(mode), .ch_edge_level_i(el),
      .ch_irq_enable_i(cie), .ch_value_wr_i(cvw), .ch_value_data_i(cvd),
      .ch_status_rd_i(csr), .ch_flag_wr_i(cfw), .ch_flag_wr_data_i(2'h0),
      .ch_value_o(cval), .ch_flag_o(cflag), .ch_irq_o(cirq),
      .port_a_upper_pins_i(pin), .port_a_upper_pins_o(pout),
      .port_a_upper_pins_oe_o(poe));
   tpwm_pins_model far (.drive_i(drv), .pin_o_i(pout), .pin_oe_i(poe),
      .pin_level_o(pin), .xtal_o(xtal), .slow_o(slow));
   // 50 MHz system clock
   always #10 clk = ~clk;
   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string m, input logic [15:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // A used-up wait counts as a mismatch and ends the run
   task automatic limit(input int k);
      if (k >= 400) begin
         error_cnt++;
         report_and_stop();
      end
   endtask
   task automatic wait_chg(output int k);
      tpwm_count_t c0;
      c0 = cnt;
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (cnt === c0 && k < 400);
      limit(k);
   endtask
   task automatic wait_val(input tpwm_count_t v);
      int k;
      for (k = 0; k < 400 && cnt !== v; k++)
         @(negedge clk);
      limit(k);
   endtask
   // First change aligns to the prescaler, the second is measured
   task automatic gap(output int n);
      wait_chg(n);
      wait_chg(n);
   endtask
   task automatic cnt_wr(input logic hi);
      @(negedge clk);
      cwh = hi;
      cwl = !hi;
      @(negedge clk);
      cwh = 1'b0;
      cwl = 1'b0;
   endtask
   // Status read, then flag write in the following cycle
   task automatic clr_ovf(input logic d);
      @(negedge clk);
      srd = 1'b1;
      @(negedge clk);
      srd = 1'b0;
      owr = 1'b1;
      owd = d;
      @(negedge clk);
      owr = 1'b0;
   endtask
   task automatic clr_ch(input int i);
      @(negedge clk);
      csr[i] = 1'b1;
      @(negedge clk);
      csr[i] = 1'b0;
      cfw[i] = 1'b1;
      @(negedge clk);
      cfw[i] = 1'b0;
   endtask
   task automatic val_wr(input int i, input logic [15:0] v);
      cvd[i] = v;
      cvw[i] = 1'b1;
      @(negedge clk);
      cvw[i] = 1'b0;
   endtask
   // Main sequence
   initial begin
      int n;
      tpwm_count_t t, s;
      cyc(20);
      nrst = 1'b1;
      cyc(2);
      chk("reset", cnt | {flag, irq, cflag, poe}, 16'h0000);
      sh = 1'b1;
      cyc(10);
      chk("stopped", cnt, 16'h0000);
      // Bus clock through all eight prescale taps
      sh = 1'b0;
      sl = 1'b1;
      for (int c = 0; c < 8; c++) begin
         ps = c[2:0];
         gap(n);
         chk("tap", n[15:0], 16'h0001 << c);
      end
      ps = 3'h0;
      cnt_wr(1'b1);
      chk("write high", cnt, 16'h0000);
      cyc(5);
      chk("counting", cnt, 16'h0005);
      cnt_wr(1'b0);
      chk("write low", cnt, 16'h0000);
      sh = 1'b1;
      gap(n);
      chk("crystal", n[15:0], 16'h0064);
      // Modulo five: tops out at five, then flags overflow
      sh = 1'b0;
      modv = 16'h0005;
      oie = 1'b1;
      cnt_wr(1'b1);
      t = 16'h0000;
      repeat (14) begin
         @(negedge clk);
         t = (cnt > t) ? cnt : t;
      end
      chk("top", t, 16'h0005);
      chk("ovf irq", {flag, irq}, 16'h0003);
      sl = 1'b0;
      oie = 1'b0;
      cyc(1);
      chk("irq masked", irq, 16'h0000);
      clr_ovf(1'b1);
      chk("write one", flag, 16'h0001);
      clr_ovf(1'b0);
      chk("cleared", flag, 16'h0000);
      // Modulo zero gives the full sixteen-bit range
      modv = 16'h0000;
      sl = 1'b1;
      cnt_wr(1'b0);
      cyc(65530);
      chk("no early wrap", flag, 16'h0000);
      cyc(10);
      chk("wrapped", flag, 16'h0001);
      clr_ovf(1'b0);
      // Center mode turns the count down after the modulo value
      modv = 16'h0003;
      cpw = 1'b1;
      cnt_wr(1'b1);
      wait_val(16'h0003);
      wait_chg(n);
      chk("turn down", cnt, 16'h0002);
      chk("down flag", flag, 16'h0001);
      // Capture on pin 1 for each edge choice
      cpw = 1'b0;
      modv = 16'h0000;
      cie = 2'h3;
      for (int e = 1; e < 4; e++) begin
         el[1] = e[1:0];
         clr_ch(1);
         t = cnt;
         drv[1] = 1'b1;
         cyc(3);
         chk("rise", cflag[1], e != 2);
         chk("ch irq", cirq[1], e != 2);
         // A rise-blind setting must keep the last stamp taken
         s = (e != 2) ? t : s;
         chk("stamp", cval[1], s);
         clr_ch(1);
         drv[1] = 1'b0;
         cyc(3);
         chk("fall", cflag[1], e != 1);
      end
      // Channel 0 fed by the slow oscillator, then by its idle pin
      el[0] = 2'h1;
      for (int r = 1; r >= 0; r--) begin
         rte = r[0];
         clr_ch(0);
         cyc(400);
         chk("slow osc", cflag[0], r[0]);
      end
      // Compare on pin 1: set, clear, toggle, one match per period
      modv = 16'h0014;
      cnt_wr(1'b1);
      mode[1] = 2'h1;
      val_wr(1, 16'h000A);
      for (int a = 3; a > 0; a--) begin
         el[1] = a[1:0];
         cyc(21);
         chk("compare", {poe[1], pout[1]}, {1'b1, a != 2});
      end
      // Edge PWM on pin 0, high-true then low-true, duty four of ten
      modv = 16'h0009;
      cnt_wr(1'b0);
      mode[0] = 2'h2;
      val_wr(0, 16'h0004);
      for (int p = 0; p < 2; p++) begin
         el[0] = p ? 2'h1 : 2'h2;
         cyc(25);
         n = 0;
         repeat (10) begin
            @(negedge clk);
            n += pin[0];
         end
         chk("duty", n[15:0], p ? 16'h0006 : 16'h0004);
      end
      el[0] = 2'h0;
      cyc(2);
      chk("released", poe, 16'h0002);
      report_and_stop();
   end
endmodule // tb_top
bind tpwm_top tpwm_properties #(.NUM_CH(NUM_CH)) u_props (.clock_i, .nrst_i,
   .clock_select_high_i, .clock_select_low_i, .prescale_code_i,
   .center_aligned_pwm_i, .overflow_irq_enable_i, .modulo_value_high_i,
   .modulo_value_low_i, .counter_wr_high_i, .counter_wr_low_i,
   .counter_value_o, .status_rd_i, .overflow_wr_i, .overflow_wr_data_i,
   .overflow_flag_o, .overflow_irq_o, .ch_mode_i, .ch_edge_level_i,
   .ch_value_wr_i, .ch_value_o, .ch_flag_o, .port_a_upper_pins_i,
   .port_a_upper_pins_o, .port_a_upper_pins_oe_o);
